// [src/sipol_top.sv]
// serial-in parallel-out latch with three-state outputs
`timescale 1ns/1ps
`default_nettype none
`include "sipol_params.svh"
module sipol_top (
   // clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst_b,
   // serial side
   input  wire logic                  serial_in,
   input  wire logic                  shift_clock,
   input  wire logic                  shift_clear_n,
   // store side
   input  wire logic                  store_clock,
   input  wire logic                  out_enable_n,
   // outputs
   output sipol_pkg::sipol_byte_t     parallel_out,
   output logic [`SIPOL_WIDTH-1:0]    parallel_oe,
   output logic                       cascade_out
);
   // -------------------------------------------------------------
   // edge detection
   // -------------------------------------------------------------
   logic shift_rise;
   logic store_rise;

   sipol_edge u_shift_edge (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .pin_in   (shift_clock),
      .rise     (shift_rise)
   );

   sipol_edge u_store_edge (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .pin_in   (store_clock),
      .rise     (store_rise)
   );

   // -------------------------------------------------------------
   // shift register
   // -------------------------------------------------------------
   sipol_pkg::sipol_byte_t shift_r;
   sipol_pkg::sipol_byte_t shift_nxt;

   always_comb begin
      shift_nxt = shift_r;
      if (shift_rise) begin
         shift_nxt = {shift_r[`SIPOL_WIDTH-2:0], serial_in};
      end
   end

   // clear is a second async reset, beating any shift edge
   always_ff @(posedge core_clk or negedge rst_b or negedge shift_clear_n) begin
      if (!rst_b) begin
         shift_r <= `SIPOL_SHIFT_RST;
      end else if (!shift_clear_n) begin
         shift_r <= `SIPOL_SHIFT_RST;
      end else begin
         shift_r <= shift_nxt;
      end
   end

   // -------------------------------------------------------------
   // storage register
   // -------------------------------------------------------------
   sipol_pkg::sipol_byte_t store_r;
   sipol_pkg::sipol_byte_t store_nxt;

   always_comb begin
      store_nxt = store_r;
      if (store_rise) begin
         store_nxt = shift_r;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         store_r <= `SIPOL_STORE_RST;
      end else begin
         store_r <= store_nxt;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   assign parallel_out = store_r;
   assign parallel_oe  = {`SIPOL_WIDTH{~out_enable_n}};
   assign cascade_out  = shift_r[`SIPOL_WIDTH-1];

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   a_shift_step: assert property (@(posedge core_clk) disable iff (!rst_b)
      (shift_clear_n && $rose(shift_clock)) |=> shift_clear_n |->
      shift_r == {$past(shift_r[`SIPOL_WIDTH-2:0]), $past(serial_in)})
      else $error("shift step wrong");
   a_shift_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      (shift_clear_n && !shift_rise) |=> shift_clear_n |->
      $stable(shift_r))
      else $error("shift changed without edge");
   a_clear_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
      !shift_clear_n |-> shift_r == `SIPOL_SHIFT_RST && !cascade_out)
      else $error("clear failed");
   a_clear_store: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!shift_clear_n && !store_rise) |=> $stable(parallel_out))
      else $error("clear hit storage");
   a_store_load: assert property (@(posedge core_clk) disable iff (!rst_b)
      store_rise |=> parallel_out == $past(shift_r))
      else $error("store load wrong");
   a_store_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!store_rise ##1 1'b1) |-> $stable(parallel_out))
      else $error("storage changed");
   a_out_enable: assert property (@(posedge core_clk) disable iff (!rst_b)
      parallel_oe == (out_enable_n ? 8'h00 : 8'hFF))
      else $error("enable wrong");
   a_cascade_tap: assert property (@(posedge core_clk) disable iff (!rst_b)
      ($rose(shift_clock) && shift_clear_n) ##1 shift_clear_n |->
      cascade_out == $past(shift_r[`SIPOL_WIDTH-2]))
      else $error("cascade wrong");

   // -------------------------------------------------------------
   // shift side checks
   // -------------------------------------------------------------
   a_shift_first: assert property (@(posedge core_clk) disable iff (!rst_b)
      (shift_clear_n && shift_rise) |=> shift_clear_n |->
      shift_r[0] == $past(serial_in))
      else $error("first stage wrong");

   a_rise_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
      shift_rise |=> !shift_rise)
      else $error("shift rise too long");

   a_clear_async: assert property (@(posedge core_clk) disable iff (!rst_b)
      $fell(shift_clear_n) |-> shift_r == `SIPOL_SHIFT_RST)
      else $error("clear not immediate");

   a_clear_beats: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!shift_clear_n && shift_rise) |=> !shift_clear_n |->
      shift_r == `SIPOL_SHIFT_RST)
      else $error("shift beat clear");

   a_cascade_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
      (shift_clear_n && !shift_rise) |=> shift_clear_n |->
      $stable(cascade_out))
      else $error("cascade moved");

   a_cascade_free: assert property (@(posedge core_clk) disable iff (!rst_b)
      cascade_out == shift_r[`SIPOL_WIDTH-1])
      else $error("cascade gated");

   a_store_no_shift: assert property (@(posedge core_clk) disable iff (!rst_b)
      (shift_clear_n && !shift_rise && store_rise) |=> shift_clear_n |->
      $stable(shift_r))
      else $error("store moved shift");

   // -------------------------------------------------------------
   // storage side checks
   // -------------------------------------------------------------
   a_store_steady: assert property (@(posedge core_clk) disable iff (!rst_b)
      (shift_rise && !store_rise) |=> $stable(parallel_out))
      else $error("outputs moved while shifting");

   a_same_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
      (shift_rise && store_rise) |=> parallel_out == $past(shift_r))
      else $error("store took shifted value");

   a_clear_load: assert property (@(posedge core_clk) disable iff (!rst_b)
      (!shift_clear_n && store_rise) |=>
      parallel_out == `SIPOL_SHIFT_RST)
      else $error("store during clear wrong");

   a_store_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
      store_rise |=> !store_rise)
      else $error("store rise too long");

   a_out_source: assert property (@(posedge core_clk) disable iff (!rst_b)
      parallel_out == store_r)
      else $error("outputs not from storage");

   // -------------------------------------------------------------
   // enable checks
   // -------------------------------------------------------------
   a_oe_on: assert property (@(posedge core_clk) disable iff (!rst_b)
      !out_enable_n |-> &parallel_oe)
      else $error("outputs not driven");

   a_oe_off: assert property (@(posedge core_clk) disable iff (!rst_b)
      out_enable_n |-> !(|parallel_oe))
      else $error("outputs not floated");

   a_oe_even: assert property (@(posedge core_clk) disable iff (!rst_b)
      parallel_oe == {`SIPOL_WIDTH{parallel_oe[0]}})
      else $error("enable bits split");

endmodule : sipol_top
`default_nettype wire

// [shared/sipol_params.svh]
// constants for the serial-in parallel-out latch
// How it works
// - eight-stage shift register feeds an eight-stage storage register driving outputs
// - shift register advances only on a rising shift clock edge
// - rising store clock edge copies all eight stages into storage at once
// - shift and store clocks independent; outputs steady while shifting
// - enable high floats all parallel outputs, cascade output stays driven; low drives storage contents
// - clear low forces every shift stage low regardless of other inputs
// - on shift edge, first stage takes serial input, others take predecessor
// - without shift edge and clear high, shift contents are kept
// - without store edge, storage keeps contents whatever the shift side does
`ifndef SIPOL_PARAMS_SVH
`define SIPOL_PARAMS_SVH
`define SIPOL_WIDTH      8
`define SIPOL_SHIFT_RST  8'h00
`define SIPOL_STORE_RST  8'h00
`endif

// [shared/sipol_pkg.sv]
// types for the serial-in parallel-out latch
`include "sipol_params.svh"
package sipol_pkg;
   typedef logic [`SIPOL_WIDTH-1:0] sipol_byte_t;
endpackage : sipol_pkg

// [src/sipol_edge.sv]
// rising edge detector for a synchronous input pin
`timescale 1ns/1ps
`default_nettype none
module sipol_edge (
   // clock and reset
   input  wire logic core_clk,
   input  wire logic rst_b,
   // pin
   input  wire logic pin_in,
   output logic      rise
);
   logic prev_r;
   logic prev_nxt;

   always_comb begin
      prev_nxt = pin_in;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prev_r <= 1'b0;
      end else begin
         prev_r <= prev_nxt;
      end
   end

   assign rise = pin_in & ~prev_r;
endmodule : sipol_edge
`default_nettype wire

// [testbench/sipol_ctl.sv]
// controller model driving serial bits and both clocks
`timescale 1ns/1ps
`default_nettype none
module sipol_ctl (
   // pins toward the latch
   input  wire logic core_clk,
   output logic      serial_in = 1'b0,
   output logic      shift_clock = 1'b0,
   output logic      store_clock = 1'b0
);
   // eight bits, first bit first, one cycle high and low per bit
   task automatic shift_byte(input logic [7:0] d);
      for (int i = 7; i >= 0; i--) begin
         @(posedge core_clk) #1;
         serial_in = d[i];
         shift_clock = 1'b1;
         @(posedge core_clk) #1;
         shift_clock = 1'b0;
         serial_in = ~d[i];
      end
   endtask : shift_byte
   // one store pulse after the byte is in
   task automatic store_byte();
      @(posedge core_clk) #1;
      store_clock = 1'b1;
      @(posedge core_clk) #1;
      store_clock = 1'b0;
      @(posedge core_clk) #1;
   endtask : store_byte
endmodule : sipol_ctl
`default_nettype wire

// [testbench/sipol_top_tb.sv]
// self-checking bench for the serial-in parallel-out latch
`timescale 1ns/1ps
`default_nettype none
module sipol_top_tb;
   logic                   core_clk, rst_b, shift_clear_n, out_enable_n;
   logic                   serial_in, shift_clock, store_clock, cascade_out;
   sipol_pkg::sipol_byte_t parallel_out;
   logic [7:0]             parallel_oe;
   int                     bad_count = 0;
   int                     n_compared = 0;
   sipol_ctl u_ctl (.core_clk(core_clk), .serial_in(serial_in),
      .shift_clock(shift_clock), .store_clock(store_clock));
   sipol_top u_dut (.core_clk(core_clk), .rst_b(rst_b),
      .serial_in(serial_in), .shift_clock(shift_clock),
      .shift_clear_n(shift_clear_n), .store_clock(store_clock),
      .out_enable_n(out_enable_n), .parallel_out(parallel_out),
      .parallel_oe(parallel_oe), .cascade_out(cascade_out));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic t_shift_store();
      u_ctl.shift_byte(8'hA5);
      chk(parallel_out, 8'h00);
      chk({7'h00, cascade_out}, 8'h01);
      u_ctl.store_byte();
      chk(parallel_out, 8'hA5);
      $display("test shift_store done");
   endtask : t_shift_store
   task automatic t_clear();
      u_ctl.shift_byte(8'h81);
      shift_clear_n = 1'b0;
      @(posedge core_clk) #1;
      chk({7'h00, cascade_out}, 8'h00);
      chk(parallel_out, 8'hA5);
      u_ctl.shift_byte(8'hFF);
      shift_clear_n = 1'b1;
      repeat (3) @(posedge core_clk) #1;
      u_ctl.store_byte();
      chk(parallel_out, 8'h00);
      $display("test clear done");
   endtask : t_clear
   task automatic t_enable();
      out_enable_n = 1'b1;
      #1 chk(parallel_oe, 8'h00);
      out_enable_n = 1'b0;
      #1 chk(parallel_oe, 8'hFF);
      $display("test enable done");
   endtask : t_enable
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      rst_b = 1'b0;
      shift_clear_n = 1'b1;
      out_enable_n = 1'b0;
      repeat (6) @(posedge core_clk);
      #1 rst_b = 1'b1;
      t_shift_store();
      t_clear();
      t_enable();
      summarize();
   end
   initial begin
      #100000;
      bad_count++;
      summarize();
   end
endmodule : sipol_top_tb
`default_nettype wire
